//--- pio_pkg.sv
package pio_pkg;

  // ------------------------------------------------------------
  // port widths
  // ------------------------------------------------------------
  localparam int PIO_WIDE_W   = 8;
  localparam int PIO_NARROW_W = 3;

  // ------------------------------------------------------------
  // register offsets within one port (address bits [1:0])
  // ------------------------------------------------------------
  localparam logic [1:0] PIO_OFF_LEVEL = 2'h0;
  localparam logic [1:0] PIO_OFF_OUT   = 2'h1;
  localparam logic [1:0] PIO_OFF_DIR   = 2'h2;
  localparam logic [1:0] PIO_OFF_DRIVE = 2'h3;

  // ------------------------------------------------------------
  // port select (address bits [4:2]) and readback-only sources
  // ------------------------------------------------------------
  localparam logic [2:0] PIO_PORT_FIRST  = 3'h0;
  localparam logic [2:0] PIO_PORT_SECOND = 3'h1;
  localparam logic [2:0] PIO_PORT_THIRD  = 3'h2;
  localparam logic [2:0] PIO_MCELL_FIRST = 3'h3;
  localparam logic [2:0] PIO_MCELL_SECND = 3'h4;
  localparam logic [2:0] PIO_INMC_FIRST  = 3'h5;
  localparam logic [2:0] PIO_INMC_SECND  = 3'h6;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] PIO_RST_OUT   = 8'h00;
  localparam logic [7:0] PIO_RST_DIR   = 8'h00;
  localparam logic [7:0] PIO_RST_DRIVE = 8'h00;

  // ------------------------------------------------------------
  // pin source select and input macrocell mode encodings
  // ------------------------------------------------------------
  localparam logic [1:0] PIO_SRC_HOST   = 2'h0;
  localparam logic [1:0] PIO_SRC_MCELL  = 2'h1;
  localparam logic [1:0] PIO_SRC_EXTSEL = 2'h2;
  localparam logic [1:0] PIO_SRC_JTAG   = 2'h3;

  localparam logic [1:0] PIO_IMC_DIRECT = 2'h0;
  localparam logic [1:0] PIO_IMC_LATCH  = 2'h1;
  localparam logic [1:0] PIO_IMC_REG    = 2'h2;

  // first open-drain capable bit of the first port
  localparam int PIO_OD_LOW_FIRST = 4;

endpackage : pio_pkg

//--- pio_input_macrocell.sv
`timescale 1ns/1ns
module pio_input_macrocell
  import pio_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pin_level,
  input  wire logic [1:0]   mode,
  input  wire logic         clk_pt_low,
  input  wire logic         clk_pt_high,
  output logic      [W-1:0] cell_out
);

  // ------------------------------------------------------------
  // per-bit register / latch / direct input cell
  // ------------------------------------------------------------
  logic [W-1:0] held_reg;
  logic [W-1:0] pt_prev_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_cell
      logic pt;
      // one product term serves each half of the port
      assign pt = (i < W/2) ? clk_pt_low : clk_pt_high;

      // register on the product-term rising edge, latch while high
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          held_reg[i]    <= 1'b0;
          pt_prev_reg[i] <= 1'b0;
        end else begin
          pt_prev_reg[i] <= pt;
          if (mode == PIO_IMC_REG && pt && !pt_prev_reg[i]) begin
            held_reg[i] <= pin_level[i];
          end else if (mode == PIO_IMC_LATCH && pt) begin
            held_reg[i] <= pin_level[i];
          end
        end
      end

      // latch is transparent, so pass the pin while the term is high
      always_comb begin
        if (mode == PIO_IMC_DIRECT || (mode == PIO_IMC_LATCH && pt)) begin
          cell_out[i] = pin_level[i];
        end else begin
          cell_out[i] = held_reg[i];
        end
      end
    end
  endgenerate

endmodule : pio_input_macrocell

//--- pio_ports.sv
`timescale 1ns/1ns
// Overview of operation
// (RULE_01) three ports: two eight-bit, one three-bit, each pin configured alone
// (RULE_02) per-pin output mux: data-out bit, macrocell output, or external select
// (RULE_03) readback buffer drives one selected source onto the data bus per read
// (RULE_04) driver enable is enable product term OR direction bit
// (RULE_05) with no enable term and no logic output, direction alone drives enable
// (RULE_06) eight-bit port pins have register/latch/direct input cells, readable by host
// (RULE_07) first group to first port, second to second, selects to three-bit port
// (RULE_08) three-bit port inputs go straight to logic; wide ports via input cells
// (RULE_09) jtag pins only on second port, muxed with its other functions
// (RULE_10) host mode: output pin follows data-out; input pin readable via data-in
// (RULE_11) logic output tri-stated when enable term inactive and direction bit zero
// (RULE_12) host never sets direction one on a pin used as logic input
// (RULE_13) bit n controls pin n; all configuration bits reset to zero
// (RULE_14) data-in read returns the actual pin level at any time
// (RULE_15) data-out always read/writable; reaches pin only when logic not driving
// (RULE_16) direction one is output, zero is input; all inputs after reset
// (RULE_17) readback covers data-out, macrocells, direction and pin inputs
// (RULE_18) third port implements only the three low direction bits
// (RULE_19) drive-select one gives open drain where offered, else push-pull
// (RULE_20) writes taken from low data byte on trailing edge of write strobe
module pio_ports
  import pio_pkg::*;
#(
  parameter int WW = PIO_WIDE_W,
  parameter int NW = PIO_NARROW_W
) (
  input  wire logic          ref_clk,
  input  wire logic          rstn,

  // host parallel bus
  input  wire logic          sel_n,
  input  wire logic          wr_n,
  input  wire logic          rd_n,
  input  wire logic [4:0]    addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata,
  output logic               rdata_oe,

  // static pin configuration
  input  wire logic [2*WW-1:0] src_first,
  input  wire logic [2*WW-1:0] src_second,
  input  wire logic [2*NW-1:0] src_third,
  input  wire logic [WW-1:0] oe_term_def_first,
  input  wire logic [WW-1:0] oe_term_def_second,
  input  wire logic [NW-1:0] oe_term_def_third,
  input  wire logic [1:0]    imc_mode_first,
  input  wire logic [1:0]    imc_mode_second,

  // logic array side
  input  wire logic [WW-1:0] macrocell_group_first,
  input  wire logic [WW-1:0] macrocell_group_second,
  input  wire logic [NW-1:0] external_select_outputs,
  input  wire logic [WW-1:0] oe_term_first,
  input  wire logic [WW-1:0] oe_term_second,
  input  wire logic [NW-1:0] oe_term_third,
  input  wire logic [1:0]    imc_clk_pt_first,
  input  wire logic [1:0]    imc_clk_pt_second,
  input  wire logic [WW-1:0] jtag_out,
  input  wire logic [WW-1:0] jtag_oe,
  output logic      [WW-1:0] logic_in_first,
  output logic      [WW-1:0] logic_in_second,
  output logic      [NW-1:0] logic_in_third,

  // pins
  input  wire logic [WW-1:0] pin_in_first,
  input  wire logic [WW-1:0] pin_in_second,
  input  wire logic [NW-1:0] pin_in_third,
  output logic      [WW-1:0] pin_out_first,
  output logic      [WW-1:0] pin_out_second,
  output logic      [NW-1:0] pin_out_third,
  output logic      [WW-1:0] pin_oe_first,
  output logic      [WW-1:0] pin_oe_second,
  output logic      [NW-1:0] pin_oe_third,
  output logic      [WW-1:0] slew_fast
);

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  // (RULE_01) two wide ports, one narrow
  logic [WW-1:0] out_first_reg, out_second_reg, dir_first_reg, dir_second_reg;
  logic [WW-1:0] drv_first_reg, drv_second_reg;
  logic [NW-1:0] out_third_reg, dir_third_reg, drv_third_reg;
  logic          wr_prev_reg;
  logic          wr_trail;
  logic [WW-1:0] imc_first, imc_second;

  // (RULE_20) trailing edge capture
  assign wr_trail = !wr_prev_reg && wr_n && !sel_n;

  // last sampled write strobe, idles high
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_prev_reg <= 1'b1;
    end else begin
      wr_prev_reg <= wr_n;
    end
  end

  // (RULE_13) reset to zero
  // (RULE_16) inputs after reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      out_first_reg  <= PIO_RST_OUT[WW-1:0];
      out_second_reg <= PIO_RST_OUT[WW-1:0];
      out_third_reg  <= PIO_RST_OUT[NW-1:0];
      dir_first_reg  <= PIO_RST_DIR[WW-1:0];
      dir_second_reg <= PIO_RST_DIR[WW-1:0];
      dir_third_reg  <= PIO_RST_DIR[NW-1:0];
      drv_first_reg  <= PIO_RST_DRIVE[WW-1:0];
      drv_second_reg <= PIO_RST_DRIVE[WW-1:0];
      drv_third_reg  <= PIO_RST_DRIVE[NW-1:0];
    end else if (wr_trail) begin
      // (RULE_18) narrow port keeps low bits only
      if (addr[4:2] == PIO_PORT_FIRST) begin
        if (addr[1:0] == PIO_OFF_OUT) begin
          out_first_reg <= wdata[WW-1:0];
        end else if (addr[1:0] == PIO_OFF_DIR) begin
          dir_first_reg <= wdata[WW-1:0];
        end else if (addr[1:0] == PIO_OFF_DRIVE) begin
          drv_first_reg <= wdata[WW-1:0];
        end
      end else if (addr[4:2] == PIO_PORT_SECOND) begin
        if (addr[1:0] == PIO_OFF_OUT) begin
          out_second_reg <= wdata[WW-1:0];
        end else if (addr[1:0] == PIO_OFF_DIR) begin
          dir_second_reg <= wdata[WW-1:0];
        end else if (addr[1:0] == PIO_OFF_DRIVE) begin
          drv_second_reg <= wdata[WW-1:0];
        end
      end else if (addr[4:2] == PIO_PORT_THIRD) begin
        if (addr[1:0] == PIO_OFF_OUT) begin
          out_third_reg <= wdata[NW-1:0];
        end else if (addr[1:0] == PIO_OFF_DIR) begin
          dir_third_reg <= wdata[NW-1:0];
        end else if (addr[1:0] == PIO_OFF_DRIVE) begin
          drv_third_reg <= wdata[NW-1:0];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // input macrocells on the wide ports
  // ------------------------------------------------------------
  // (RULE_06) wide port input cells
  pio_input_macrocell #(.W(WW)) u_imc_first (
    .ref_clk     (ref_clk),
    .rstn        (rstn),
    .pin_level   (pin_in_first),
    .mode        (imc_mode_first),
    .clk_pt_low  (imc_clk_pt_first[0]),
    .clk_pt_high (imc_clk_pt_first[1]),
    .cell_out    (imc_first)
  );

  pio_input_macrocell #(.W(WW)) u_imc_second (
    .ref_clk     (ref_clk),
    .rstn        (rstn),
    .pin_level   (pin_in_second),
    .mode        (imc_mode_second),
    .clk_pt_low  (imc_clk_pt_second[0]),
    .clk_pt_high (imc_clk_pt_second[1]),
    .cell_out    (imc_second)
  );

  // (RULE_08) logic inputs, narrow port registered cell-free path
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      logic_in_first  <= '0;
      logic_in_second <= '0;
      logic_in_third  <= '0;
    end else begin
      logic_in_first  <= imc_first;
      logic_in_second <= imc_second;
      logic_in_third  <= pin_in_third;
    end
  end

  // ------------------------------------------------------------
  // pin output mux and driver enable, wide ports
  // ------------------------------------------------------------
  // one mux per pin
  genvar i;
  generate
    for (i = 0; i < WW; i++) begin : g_wide
      // per-pin source and enable
      logic [1:0] s1, s2;
      logic       od1, od2;
      logic       v1, v2;
      logic       e1, e2;

      assign s1 = src_first[2*i+1:2*i];
      assign s2 = src_second[2*i+1:2*i];

      // (RULE_19) open drain only on upper half of first port, all of second
      assign od1 = (i >= PIO_OD_LOW_FIRST) && drv_first_reg[i];
      assign od2 = drv_second_reg[i];

      // (RULE_02) source select
      // (RULE_07) first group only to first port
      // (RULE_10) host mode follows data-out
      // (RULE_15) logic overrides data-out
      always_comb begin
        v1 = (s1 == PIO_SRC_MCELL) ? macrocell_group_first[i] : out_first_reg[i];
        e1 = dir_first_reg[i];

        // (RULE_04) enable term or direction
        // (RULE_05) direction alone when no term
        // (RULE_11) logic output tri-state
        if (oe_term_def_first[i] || s1 == PIO_SRC_MCELL) begin
          e1 = dir_first_reg[i] || (oe_term_def_first[i] && oe_term_first[i]);
        end
        if (s1 == PIO_SRC_MCELL && !dir_first_reg[i] && !oe_term_first[i]) begin
          e1 = 1'b0;
        end

        // (RULE_09) jtag muxed onto second port only
        if (s2 == PIO_SRC_JTAG) begin
          v2 = jtag_out[i];
          e2 = jtag_oe[i];
        end else begin
          v2 = (s2 == PIO_SRC_MCELL) ? macrocell_group_second[i] : out_second_reg[i];
          e2 = dir_second_reg[i] || (oe_term_def_second[i] && oe_term_second[i]);
        end
      end

      // open drain drives low only
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          pin_out_first[i]  <= 1'b0;
          pin_oe_first[i]   <= 1'b0;
          pin_out_second[i] <= 1'b0;
          pin_oe_second[i]  <= 1'b0;
        end else begin
          pin_out_first[i]  <= od1 ? 1'b0 : v1;
          pin_oe_first[i]   <= e1 && !(od1 && v1);
          pin_out_second[i] <= od2 ? 1'b0 : v2;
          pin_oe_second[i]  <= e2 && !(od2 && v2);
        end
      end
    end

    // ------------------------------------------------------------
    // narrow port: host data or external selects
    // ------------------------------------------------------------
    for (i = 0; i < NW; i++) begin : g_narrow
      logic [1:0] s3;
      logic       v3;

      assign s3 = src_third[2*i+1:2*i];

      // (RULE_07) selects only to narrow port
      assign v3 = (s3 == PIO_SRC_EXTSEL) ? external_select_outputs[i] : out_third_reg[i];

      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          pin_out_third[i] <= 1'b0;
          pin_oe_third[i]  <= 1'b0;
        end else begin
          pin_out_third[i] <= v3;
          // (RULE_04) enable or
          pin_oe_third[i]  <= dir_third_reg[i] || (oe_term_def_third[i] && oe_term_third[i]);
        end
      end
    end
  endgenerate

  // slew control: low half of first port, all three bits of narrow port
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      slew_fast <= '0;
    end else begin
      slew_fast <= {{(WW-NW-PIO_OD_LOW_FIRST){1'b0}}, drv_third_reg,
                    drv_first_reg[PIO_OD_LOW_FIRST-1:0]};
    end
  end

  // ------------------------------------------------------------
  // readback buffer
  // ------------------------------------------------------------
  logic [7:0] rd_next;

  // (RULE_03) exactly one source
  // (RULE_14) live pin level
  // (RULE_17) all sources readable
  always_comb begin
    rd_next = 8'h00;
    if (addr[4:2] == PIO_PORT_FIRST) begin
      // first port registers
      if (addr[1:0] == PIO_OFF_LEVEL) begin
        rd_next[WW-1:0] = pin_in_first;
      end else if (addr[1:0] == PIO_OFF_OUT) begin
        rd_next[WW-1:0] = out_first_reg;
      end else if (addr[1:0] == PIO_OFF_DIR) begin
        rd_next[WW-1:0] = dir_first_reg;
      end else begin
        rd_next[WW-1:0] = drv_first_reg;
      end
    end else if (addr[4:2] == PIO_PORT_SECOND) begin
      // second port registers
      if (addr[1:0] == PIO_OFF_LEVEL) begin
        rd_next[WW-1:0] = pin_in_second;
      end else if (addr[1:0] == PIO_OFF_OUT) begin
        rd_next[WW-1:0] = out_second_reg;
      end else if (addr[1:0] == PIO_OFF_DIR) begin
        rd_next[WW-1:0] = dir_second_reg;
      end else begin
        rd_next[WW-1:0] = drv_second_reg;
      end
    end else if (addr[4:2] == PIO_PORT_THIRD) begin
      // narrow port, upper bits read zero
      if (addr[1:0] == PIO_OFF_LEVEL) begin
        rd_next[NW-1:0] = pin_in_third;
      end else if (addr[1:0] == PIO_OFF_OUT) begin
        rd_next[NW-1:0] = out_third_reg;
      end else if (addr[1:0] == PIO_OFF_DIR) begin
        rd_next[NW-1:0] = dir_third_reg;
      end else begin
        rd_next[NW-1:0] = drv_third_reg;
      end
    end else if (addr[4:2] == PIO_MCELL_FIRST) begin
      rd_next[WW-1:0] = macrocell_group_first;
    end else if (addr[4:2] == PIO_MCELL_SECND) begin
      rd_next[WW-1:0] = macrocell_group_second;
    end else if (addr[4:2] == PIO_INMC_FIRST) begin
      rd_next[WW-1:0] = imc_first;
    end else if (addr[4:2] == PIO_INMC_SECND) begin
      rd_next[WW-1:0] = imc_second;
    end
  end

  // bus released whenever the read strobe is idle
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata    <= 8'h00;
      rdata_oe <= 1'b0;
    end else begin
      rdata    <= (!sel_n && !rd_n) ? rd_next : 8'h00;
      rdata_oe <= !sel_n && !rd_n;
    end
  end

endmodule : pio_ports

//--- pio_pin_model.sv
`timescale 1ns/1ns
module pio_pin_model #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en,
  output logic      [W-1:0] pin_in
);
  // ------------------------------------------------------------
  // pin resolution
  // ------------------------------------------------------------
  // device driver wins, far driver only on a released pin, else pull-up
  // external pull-up present
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
    end
  end
endmodule : pio_pin_model

//--- pio_ports_checker.sv
`timescale 1ns/1ns
module pio_ports_checker
  import pio_pkg::*;
#(
  parameter int WW = PIO_WIDE_W,
  parameter int NW = PIO_NARROW_W
) (
  input wire logic            ref_clk,
  input wire logic            rstn,
  input wire logic            sel_n,
  input wire logic            wr_n,
  input wire logic            rd_n,
  input wire logic [4:0]      addr,
  input wire logic [7:0]      wdata,
  input wire logic [7:0]      rdata,
  input wire logic            rdata_oe,
  input wire logic [2*WW-1:0] src_first,
  input wire logic [2*WW-1:0] src_second,
  input wire logic [2*NW-1:0] src_third,
  input wire logic [WW-1:0]   oe_term_def_first,
  input wire logic [WW-1:0]   oe_term_first,
  input wire logic [WW-1:0]   macrocell_group_first,
  input wire logic [NW-1:0]   external_select_outputs,
  input wire logic [WW-1:0]   jtag_out,
  input wire logic [WW-1:0]   jtag_oe,
  input wire logic [NW-1:0]   logic_in_third,
  input wire logic [NW-1:0]   pin_in_third,
  input wire logic [WW-1:0]   pin_out_first,
  input wire logic [WW-1:0]   pin_out_second,
  input wire logic [NW-1:0]   pin_out_third,
  input wire logic [WW-1:0]   pin_oe_first,
  input wire logic [WW-1:0]   pin_oe_second,
  input wire logic [NW-1:0]   pin_oe_third
);
  logic          wr_q;
  logic [1:0]    up_q;
  logic [WW-1:0] out_sh, dir_sh, drv_sh;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // ------------------------------------------------------------
  // shadow of the first port registers
  // ------------------------------------------------------------
  // bus writes replayed; up_q masks reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_q   <= 1'b1;
      up_q   <= 2'b00;
      out_sh <= '0;
      dir_sh <= '0;
      drv_sh <= '0;
    end else begin
      wr_q <= wr_n;
      up_q <= {up_q[0], 1'b1};
      if (wr_n && !wr_q && !sel_n && addr[4:2] == PIO_PORT_FIRST) begin
        if (addr[1:0] == PIO_OFF_OUT) out_sh <= wdata;
        if (addr[1:0] == PIO_OFF_DIR) dir_sh <= wdata;
        if (addr[1:0] == PIO_OFF_DRIVE) drv_sh <= wdata;
      end
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  rd_idle_a: assert property ((sel_n || rd_n) |=> (!rdata_oe && rdata == 8'h00))
    else $error("read data without read");
  rd_drive_a: assert property ((!sel_n && !rd_n) |=> rdata_oe)
    else $error("read buffer not enabled");
  dir_alone_a: assert property (up_q[1] && src_first == '0 && oe_term_def_first == '0
    && drv_sh == '0 |=> pin_oe_first == $past(dir_sh))
    else $error("enable not direction");
  host_out_a: assert property (up_q[1] && src_first == '0 && drv_sh == '0
    |=> (pin_out_first & pin_oe_first) == ($past(out_sh) & pin_oe_first))
    else $error("pin not from data out");
  oe_or_a: assert property (up_q[1] && src_first == 16'h5555 && drv_sh == '0
    && oe_term_def_first == '1 |=> pin_oe_first == ($past(dir_sh) | $past(oe_term_first)))
    else $error("enable not term or direction");
  mcell_out_a: assert property (up_q[1] && src_first == 16'h5555 && drv_sh == '0
    |=> (pin_out_first & pin_oe_first) == ($past(macrocell_group_first) & pin_oe_first))
    else $error("first port not from its group");
  jtag_a: assert property (up_q[1] && src_second == 16'hffff |=>
    pin_oe_second == $past(jtag_oe) && (pin_out_second & jtag_oe) == ($past(jtag_out) & jtag_oe))
    else $error("jtag not on second port");
  ext_sel_a: assert property (up_q[1] && src_third == 6'h2a |=> (pin_out_third & pin_oe_third)
    == ($past(external_select_outputs) & pin_oe_third))
    else $error("third port not from selects");
  third_in_a: assert property (up_q[1] |=> logic_in_third == $past(pin_in_third))
    else $error("third input not direct");
endmodule : pio_ports_checker

bind pio_ports pio_ports_checker #(
  .WW(WW),
  .NW(NW)
) pio_ports_checker_inst (.*);

//--- pio_ports_tb.sv
`timescale 1ns/1ns
module pio_ports_tb;
  import pio_pkg::*;
  // ------------------------------------------------------------
  // signals named as design ports
  // ------------------------------------------------------------
  logic        ref_clk = 1'b0, rstn = 1'b0, sel_n = 1'b1, wr_n = 1'b1, rd_n = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic [7:0]  wdata = 8'h00, rdata, slew_fast;
  logic        rdata_oe;
  logic [15:0] src_first = 16'h0000, src_second = 16'h0000;
  logic [5:0]  src_third = 6'h00;
  logic [7:0]  oe_term_def_first = 8'h00, oe_term_def_second = 8'h00;
  logic [2:0]  oe_term_def_third = 3'h0, external_select_outputs = 3'h0, oe_term_third = 3'h0;
  logic [1:0]  imc_mode_first = 2'h0, imc_mode_second = 2'h0;
  logic [1:0]  imc_clk_pt_first = 2'h0, imc_clk_pt_second = 2'h0;
  logic [7:0]  macrocell_group_first = 8'h00, macrocell_group_second = 8'h00;
  logic [7:0]  oe_term_first = 8'h00, oe_term_second = 8'h00, jtag_out = 8'h00, jtag_oe = 8'h00;
  logic [7:0]  logic_in_first, logic_in_second, pin_in_first, pin_in_second;
  logic [2:0]  logic_in_third, pin_in_third, pin_out_third, pin_oe_third;
  logic [7:0]  pin_out_first, pin_out_second, pin_oe_first, pin_oe_second;
  logic [7:0]  xv [3];
  logic [7:0]  xe [3];
  int          out_m [3];
  int          dir_m [3];
  int          fails = 0;
  int          check_count = 0;

  always #5 ref_clk = ~ref_clk;
  pio_ports pio_ports_inst (.*);
  pio_pin_model #(.W(8)) pins_a_inst (.pin_out(pin_out_first), .pin_oe(pin_oe_first),
    .ext_val(xv[0]), .ext_en(xe[0]), .pin_in(pin_in_first));
  pio_pin_model #(.W(8)) pins_b_inst (.pin_out(pin_out_second), .pin_oe(pin_oe_second),
    .ext_val(xv[1]), .ext_en(xe[1]), .pin_in(pin_in_second));
  pio_pin_model #(.W(3)) pins_c_inst (.pin_out(pin_out_third), .pin_oe(pin_oe_third),
    .ext_val(xv[2][2:0]), .ext_en(xe[2][2:0]), .pin_in(pin_in_third));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] msk(input int p);
    return (p == 2) ? 8'h07 : 8'hff;
  endfunction : msk
  // expected level: driven, else far side, else pull-up
  function automatic logic [7:0] lvl(input int p, input logic [7:0] oe, input logic [7:0] v);
    return ((oe & v) | (~oe & ((xe[p] & xv[p]) | ~xe[p]))) & msk(p);
  endfunction : lvl
  task automatic cmp(input string what, input logic [7:0] e, input logic [7:0] got);
    check_count++;
    if (got !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, e, got);
    end
  endtask : cmp
  // write lands as the strobe rises, select low
  task automatic wr_reg(input int p, input logic [1:0] o, input logic [7:0] v);
    @(negedge ref_clk);
    sel_n = 1'b0;
    wr_n  = 1'b0;
    addr  = {p[2:0], o};
    wdata = v;
    @(negedge ref_clk);
    wr_n = 1'b1;
    @(negedge ref_clk);
    sel_n = 1'b1;
    if (p < 3 && o == PIO_OFF_OUT) out_m[p] = v & msk(p);
    if (p < 3 && o == PIO_OFF_DIR) dir_m[p] = v & msk(p);
  endtask : wr_reg
  task automatic rd_chk(input string what, input int p, input logic [1:0] o, input int e);
    @(negedge ref_clk);
    sel_n = 1'b0;
    rd_n  = 1'b0;
    addr  = {p[2:0], o};
    repeat (2) @(negedge ref_clk);
    cmp(what, e[7:0], rdata);
    rd_n  = 1'b1;
    sel_n = 1'b1;
  endtask : rd_chk
  // fresh logic-array and far-side values
  task automatic shake();
    @(negedge ref_clk);
    {macrocell_group_first, macrocell_group_second, jtag_out, jtag_oe} = $urandom;
    {oe_term_first, oe_term_second, oe_term_third, external_select_outputs,
     imc_clk_pt_first, imc_clk_pt_second} = 26'($urandom);
    {xv[0], xv[1], xv[2], xe[0]} = $urandom;
    {xe[1], xe[2]} = 16'($urandom);
  endtask : shake
  task automatic stop_test();
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    int         seed;
    int         p;
    logic [7:0] v;
    logic [7:0] e;
    seed = $urandom(32'h791f);
    xv = '{default: 8'h00};
    xe = '{default: 8'h00};
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    // all registers zero, all pins inputs
    for (int q = 0; q < 3; q++) begin
      for (int o = 1; o < 4; o++) rd_chk("reset value", q, o[1:0], 0);
    end
    cmp("oe after reset", 8'h00, pin_oe_first | pin_oe_second | {5'h00, pin_oe_third});
    // host mode: random data, direction, levels
    for (int r = 0; r < 12; r++) begin
      shake();
      for (int q = 0; q < 3; q++) begin
        wr_reg(q, PIO_OFF_OUT, 8'($urandom));
        wr_reg(q, PIO_OFF_DIR, 8'($urandom));
      end
      for (int q = 0; q < 3; q++) begin
        rd_chk("data out", q, PIO_OFF_OUT, out_m[q]);
        rd_chk("direction", q, PIO_OFF_DIR, dir_m[q]);
        rd_chk("pin level", q, PIO_OFF_LEVEL, lvl(q, dir_m[q][7:0], out_m[q][7:0]));
      end
    end
    // drive type; open drain on second port, then cleared
    for (int q = 0; q < 3; q++) begin
      v = 8'($urandom);
      wr_reg(q, PIO_OFF_DRIVE, (q == 1) ? 8'hff : v);
      rd_chk("drive type", q, PIO_OFF_DRIVE, ((q == 1) ? 8'hff : v) & msk(q));
      if (q == 0) cmp("slew", {4'h0, v[3:0]}, slew_fast);
      if (q == 1) begin
        wr_reg(1, PIO_OFF_DIR, 8'hff);
        rd_chk("open drain", 1, PIO_OFF_LEVEL, lvl(1, ~out_m[1][7:0], 8'h00));
      end
      wr_reg(q, PIO_OFF_DRIVE, 8'h00);
    end
    // logic sources: groups, jtag, external selects
    oe_term_def_first = 8'hff;
    oe_term_def_second = 8'hff;
    oe_term_def_third = 3'h7;
    for (int m = 0; m < 4; m++) begin
      p = (m + 1) / 2;
      for (int r = 0; r < 6; r++) begin
        shake();
        src_first = (m == 0) ? 16'h5555 : 16'h0000;
        src_second = (m == 1) ? 16'h5555 : ((m == 2) ? 16'hffff : 16'h0000);
        src_third = (m == 3) ? 6'h2a : 6'h00;
        wr_reg(p, PIO_OFF_DIR, 8'($urandom));
        case (m)
          0: e = lvl(0, dir_m[0][7:0] | oe_term_first, macrocell_group_first);
          1: e = lvl(1, dir_m[1][7:0] | oe_term_second, macrocell_group_second);
          2: e = lvl(1, jtag_oe, jtag_out);
          default: e = lvl(2, dir_m[2][7:0] | {5'h00, oe_term_third}, {5'h00, external_select_outputs});
        endcase
        rd_chk("logic pin level", p, PIO_OFF_LEVEL, e);
        if (m == 0) rd_chk("group readback", 3, 2'h0, macrocell_group_first);
        if (m == 1) rd_chk("group readback", 4, 2'h0, macrocell_group_second);
      end
    end
    // writes to level offset or past ports are ignored
    wr_reg(0, PIO_OFF_LEVEL, 8'h5a);
    wr_reg(7, PIO_OFF_OUT, 8'ha5);
    wr_reg(3, PIO_OFF_OUT, 8'ha5);
    rd_chk("unmapped read", 7, PIO_OFF_OUT, 0);
    for (int q = 0; q < 3; q++) rd_chk("data out kept", q, PIO_OFF_OUT, out_m[q]);
    stop_test();
  end
  // watchdog with wide margin
  initial begin
    #(30000 * 10);
    fails++;
    stop_test();
  end
endmodule : pio_ports_tb
